/* bench/mac_adc_model.sv */
// partner: converter front end echoing the selected channel in the low bits
`timescale 1ns/1ps
module mac_adc_model
  import mac_pkg::*;
(
  input  wire logic                             pclk,
  input  wire logic [mac_pkg::MAC_CHAN_W-1:0]   mux_channel,
  output logic      [mac_pkg::MAC_SAMPLE_W-1:0] adc_sample
);
  logic [6:0] noise_q = 7'h5A;
  // upper bits wander each cycle so a stale sample cannot pass for a fresh one
  always @(posedge pclk) begin
    noise_q <= {noise_q[5:0], noise_q[6] ^ noise_q[5]};
  end
  assign adc_sample = {noise_q, mux_channel};
endmodule

/* bench/mac_top_properties.sv */
// checker: bus timing and result field properties of the readout block
`timescale 1ns/1ps
module mac_top_properties
  import mac_pkg::*;
(
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic [mac_pkg::MAC_ADDR_W-1:0] paddr,
  input wire logic [31:0]                    prdata,
  input wire logic                           pready,
  input wire logic [mac_pkg::MAC_GAIN_W-1:0] pga_gain
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence waiting;
    psel && penable && !pready;
  endsequence
  sequence answered;
    pready ##1 !pready;
  endsequence
  // one wait state, then a single-cycle answer
  resp_wait_a: assert property (waiting |=> answered)
    else $error("answer late or stretched");
  resp_cause_a: assert property (pready |-> psel && penable)
    else $error("answer without access");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  data_zero_a: assert property (pready && !pwrite && paddr == MAC_OFF_DATA
    |-> prdata[31:12] == 20'h0)
    else $error("data register upper bits set");
  tag_zero_a: assert property (pready && !pwrite && paddr == MAC_OFF_TAGGED
    |-> prdata[15:12] == 4'h0 && prdata[31:21] == 11'h0)
    else $error("tagged register spare bits set");
  gain_reset_a: assert property ($rose(presetn) |-> pga_gain == MAC_GAIN_X1)
    else $error("gain not unity after reset");
  gain_legal_a: assert property (pga_gain != 2'h3)
    else $error("undefined gain code applied");
  gain_read_a: assert property (pready && !pwrite && paddr == MAC_OFF_GAIN
    |-> prdata[1:0] == pga_gain)
    else $error("gain readback differs from applied gain");
endmodule
bind mac_top mac_top_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pga_gain);

/* bench/multichannel_adc_readout_control_tb.sv */
// testbench: register, fifo, scan and trigger scenarios for the readout block
`timescale 1ns/1ps
module multichannel_adc_readout_control_tb;
  import mac_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pacer_tick, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, ch, rng;
  logic [3:0]  pstrb;
  logic [4:0]  mux_channel;
  logic [1:0]  pga_gain;
  logic [11:0] adc_sample;
  int          bad_count, num_checks, cycles, prev;
  mac_top #(.FIFO_DEPTH(8), .CONV_CYC(1)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pacer_tick,
    .adc_sample, .mux_channel, .pga_gain);
  mac_adc_model i_adc (.pclk, .mux_channel, .adc_sample);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // entered just after an edge; leaves one idle edge so no signal is driven twice
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no local limit: only the bench timeout may end a wait
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic trig(input int times);
    for (int i = 0; i < times; i++) begin
      apb(1'b1, MAC_OFF_TRIG, 32'h0);
      repeat (4) @(posedge pclk);
    end
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, pacer_tick, paddr, pwdata} = '0;
    pstrb = 4'hF;
    rng = 32'd28256;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, MAC_OFF_GAIN, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, MAC_OFF_STATUS, 32'h0);
    check(32'(rd[MAC_ST_EMPTY]), 32'h1);
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, MAC_OFF_GAIN, 32'(g));
      apb(1'b0, MAC_OFF_GAIN, 32'h0);
      check(rd, (g == 3) ? 32'h2 : 32'(g));
    end
    for (int i = 0; i < 4; i++) begin
      v = xs() & 32'hF;
      apb(1'b1, MAC_OFF_MODE, v);
      apb(1'b0, MAC_OFF_MODE, 32'h0);
      check(rd, v);
      v = xs() & 32'h1F;
      apb(1'b1, MAC_OFF_CHAN, v);
      apb(1'b0, MAC_OFF_CHAN, 32'h0);
      check(rd, v);
    end
    // nine conversions into eight places: the last one is lost
    ch = xs() & 32'h1F;
    apb(1'b1, MAC_OFF_CHAN, ch);
    apb(1'b1, MAC_OFF_MODE, 32'h5);
    apb(1'b1, MAC_OFF_FRESET, 32'h0);
    for (int i = 1; i <= 9; i++) begin
      trig(1);
      apb(1'b0, MAC_OFF_STATUS, 32'h0);
      check(32'(rd[MAC_ST_HALF]), 32'(i >= 4));
      check(32'(rd[MAC_ST_FULL]), 32'(i >= 8));
      check(32'(rd[MAC_ST_BUSY]), 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, MAC_OFF_TAGGED, 32'h0);
      check(rd & 32'hFFFF_F01F, {11'h0, ch[4:0], 11'h0, ch[4:0]});
    end
    apb(1'b0, MAC_OFF_STATUS, 32'h0);
    check(32'(rd[MAC_ST_EMPTY]), 32'h1);
    apb(1'b0, MAC_OFF_DATA, 32'h0);
    check(rd, 32'h0);
    // scan sweep wraps after the programmed last channel
    ch = (xs() & 32'h1) + 32'h1;
    apb(1'b1, MAC_OFF_CHAN, ch);
    apb(1'b1, MAC_OFF_MODE, 32'hD);
    apb(1'b1, MAC_OFF_FRESET, 32'h0);
    trig(5);
    apb(1'b0, MAC_OFF_TAGGED, 32'h0);
    prev = int'(rd[20:16]);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, MAC_OFF_TAGGED, 32'h0);
      check(32'(rd[20:16]), 32'((prev + 1) % (int'(ch) + 1)));
      check(32'(rd[4:0]), 32'(rd[20:16]));
      prev = int'(rd[20:16]);
    end
    apb(1'b1, MAC_OFF_FRESET, 32'h0);
    apb(1'b0, MAC_OFF_STATUS, 32'h0);
    check(32'(rd[MAC_ST_EMPTY]), 32'h1);
    apb(1'b1, MAC_OFF_MODE, 32'h1);
    trig(1);
    apb(1'b0, MAC_OFF_STATUS, 32'h0);
    check(32'(rd[MAC_ST_EMPTY]), 32'h1);
    apb(1'b1, MAC_OFF_MODE, 32'h3);
    pacer_tick <= 1'b1;
    @(posedge pclk);
    pacer_tick <= 1'b0;
    // status is taken while the conversion is still being stored
    apb(1'b0, MAC_OFF_STATUS, 32'h0);
    check(32'(rd[MAC_ST_BUSY]), 32'h1);
    apb(1'b0, MAC_OFF_DATA, 32'h0);
    check(rd & 32'hFFFF_F01F, ch);
    // fifo off: the last result stays put and reads do not consume it
    apb(1'b1, MAC_OFF_MODE, 32'h4);
    trig(1);
    repeat (2) begin
      apb(1'b0, MAC_OFF_TAGGED, 32'h0);
      check(rd & 32'hFFFF_F01F, {11'h0, ch[4:0], 11'h0, ch[4:0]});
    end
    apb(1'b0, 12'h020, 32'h0);
    check(32'(err), 32'h1);
    tally_and_finish();
  end
endmodule

/* logic/mac_fifo.sv */
// module: parameterised sample fifo in flip-flops with occupancy flags
`timescale 1ns/1ps
module mac_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   flush,
  mac_fifo_if.snk     wr,
  mac_fifo_if.src     rd,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rp_q];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;
  assign count    = cnt_q;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= bump(wp_q);
      end
      if (pop) begin
        rp_q <= bump(rp_q);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* logic/mac_fifo_if.sv */
// interface: valid/ready stream between the converter path and the sample fifo
`timescale 1ns/1ps
interface mac_fifo_if #(parameter int WIDTH = 17);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* logic/mac_pkg.sv */
// package: register map, fields and timing for the converter readout control
package mac_pkg;
  localparam int          MAC_ADDR_W      = 12;
  localparam logic [11:0] MAC_OFF_DATA    = 12'h000;
  localparam logic [11:0] MAC_OFF_TAGGED  = 12'h004;
  localparam logic [11:0] MAC_OFF_CHAN    = 12'h008;
  localparam logic [11:0] MAC_OFF_GAIN    = 12'h00C;
  localparam logic [11:0] MAC_OFF_MODE    = 12'h010;
  localparam logic [11:0] MAC_OFF_STATUS  = 12'h014;
  localparam logic [11:0] MAC_OFF_TRIG    = 12'h018;
  localparam logic [11:0] MAC_OFF_FRESET  = 12'h01C;
  localparam int          MAC_SAMPLE_W    = 12;
  localparam int          MAC_CHAN_W      = 5;
  localparam int          MAC_ENTRY_W     = MAC_SAMPLE_W + MAC_CHAN_W;
  localparam int          MAC_TAG_LSB     = 16;
  localparam int          MAC_GAIN_W      = 2;
  localparam logic [1:0]  MAC_GAIN_X1     = 2'h0;
  localparam logic [1:0]  MAC_GAIN_X10    = 2'h1;
  localparam logic [1:0]  MAC_GAIN_X100   = 2'h2;
  localparam int          MAC_MODE_W      = 4;
  localparam int          MAC_MODE_FIFO   = 0;
  localparam int          MAC_MODE_PACER  = 1;
  localparam int          MAC_MODE_SOFT   = 2;
  localparam int          MAC_MODE_SCAN   = 3;
  localparam int          MAC_ST_EMPTY    = 0;
  localparam int          MAC_ST_HALF     = 1;
  localparam int          MAC_ST_FULL     = 2;
  localparam int          MAC_ST_BUSY     = 3;
  localparam int          MAC_CONV_NS     = 100;
  localparam int          MAC_CLK_MHZ     = 100;
  localparam int          MAC_CONV_CYC    = (MAC_CONV_NS * MAC_CLK_MHZ + 999) / 1000;
  localparam int          MAC_FIFO_DEPTH  = 8;
endpackage

/* logic/mac_top.sv */
// module: apb register file, trigger and scan sequencing, result readout
//
// Notes on behaviour
// [R1] data register holds the 12-bit unsigned result, bit 0 lsb, bit 11 msb
// [R2] 32-bit tagged result register carries converted channel in bits 16..20
// [R3] tagged result register carries the 12-bit value in bits 0..11
// [R4] 32 channels; channel select accepts 0 to 31
// [R5] scan off: only the last written channel is converted
// [R6] scan on: channel select is the last channel of the sweep
// [R7] gain is unity after reset until software writes a new code
// [R8] gain code 0 is x1, 1 is x10, 2 is x100; reads back as written, except that a write of code 3 is ignored and the old code stays
// [R9] status shows fifo empty and fifo half-full
// [R10] status shows fifo full, meaning results may have been lost
// [R11] status shows busy while converting and writing into the fifo
// [R12] mode register takes any mix of fifo, pacer, soft trigger, scan
// [R13] mode register reads back the programmed settings
// [R14] software may read data back to back; each read yields a new result (code: only with fifo on; with fifo off each read returns the same kept result)
// [R15] a soft trigger makes one conversion whose result appears at offset 0
// [R16] fifo reset discards stored samples; software uses it before starting
// [R17] with fifo on, each result read pops the oldest and updates flags
// [R18] unused result bits 12..15 and 21..31 read as zero
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module mac_top
  import mac_pkg::*;
#(
  parameter int FIFO_DEPTH = mac_pkg::MAC_FIFO_DEPTH,
  parameter int CONV_CYC   = mac_pkg::MAC_CONV_CYC
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [mac_pkg::MAC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            pacer_tick,
  input  wire logic [mac_pkg::MAC_SAMPLE_W-1:0] adc_sample,
  output logic      [mac_pkg::MAC_CHAN_W-1:0]  mux_channel,
  output logic      [mac_pkg::MAC_GAIN_W-1:0]  pga_gain
);
  import mac_pkg::*;

  typedef enum logic [1:0] {MAC_IDLE, MAC_CONV, MAC_STORE} mac_state_t;

  localparam int CW = $clog2(CONV_CYC + 1);
  localparam int FW = $clog2(FIFO_DEPTH) + 1;

  mac_state_t                state_q;
  logic [CW-1:0]             conv_cnt_q;
  logic [MAC_CHAN_W-1:0]     channel_select_q;
  logic [MAC_CHAN_W-1:0]     scan_ch_q;
  logic [MAC_GAIN_W-1:0]     gain_code_q;
  logic [MAC_MODE_W-1:0]     mode_q;
  logic [MAC_ENTRY_W-1:0]    hold_q;
  logic [MAC_ENTRY_W-1:0]    entry_q;
  logic [31:0]               prdata_q;
  logic                      pready_q;
  logic                      pslverr_q;
  logic                      soft_req_q;
  logic                      flush_q;
  logic                      lost_q;
  logic [FW-1:0]             fcount;
  logic                      setup;
  logic                      wr_hit;
  logic                      rd_pop;
  logic                      start;
  logic                      fifo_on;
  logic [MAC_ENTRY_W-1:0]    head;

  mac_fifo_if #(.WIDTH(MAC_ENTRY_W)) push_if ();
  mac_fifo_if #(.WIDTH(MAC_ENTRY_W)) pop_if ();

  mac_fifo #(
    .WIDTH (MAC_ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .flush   (flush_q),
    .wr      (push_if.snk),
    .rd      (pop_if.src),
    .count   (fcount)
  );

  function automatic logic is_off(input logic [MAC_ADDR_W-1:0] a, input logic [11:0] off);
    return a == off[MAC_ADDR_W-1:0];
  endfunction

  function automatic logic [31:0] tag_word(input logic [MAC_ENTRY_W-1:0] e);
    logic [31:0] w;
    w = '0;
    w[MAC_SAMPLE_W-1:0] = e[MAC_SAMPLE_W-1:0];  // [R3] [R18]
    w[MAC_TAG_LSB +: MAC_CHAN_W] = e[MAC_ENTRY_W-1 -: MAC_CHAN_W];  // [R2]
    return w;
  endfunction

  // one wait state: answer in the cycle after the access phase starts
  assign setup   = psel && penable && !pready_q;
  assign wr_hit  = setup && pwrite;
  assign fifo_on = mode_q[MAC_MODE_FIFO];
  assign rd_pop  = setup && !pwrite && fifo_on &&
                   (is_off(paddr, MAC_OFF_DATA) || is_off(paddr, MAC_OFF_TAGGED));  // [R17] [R14]
  assign start   = (state_q == MAC_IDLE) && !flush_q &&
                   (soft_req_q || (mode_q[MAC_MODE_PACER] && pacer_tick));  // [R15]

  assign push_if.valid = fifo_on && (state_q == MAC_STORE);
  assign push_if.data  = hold_q;
  assign pop_if.ready  = rd_pop;
  // an empty fifo reads zero: its storage has no reset and may hold stale words
  assign head = fifo_on ? (pop_if.valid ? pop_if.data : '0) : entry_q;  // [R17]

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_select_q <= '0;
      gain_code_q      <= MAC_GAIN_X1;  // [R7]
      mode_q           <= '0;
    end else if (wr_hit) begin
      if (is_off(paddr, MAC_OFF_CHAN) && pstrb[0]) begin
        channel_select_q <= pwdata[MAC_CHAN_W-1:0];  // [R4]
      end
      if (is_off(paddr, MAC_OFF_GAIN) && pstrb[0] && pwdata[MAC_GAIN_W-1:0] != 2'h3) begin
        gain_code_q <= pwdata[MAC_GAIN_W-1:0];  // [R8]
      end
      if (is_off(paddr, MAC_OFF_MODE) && pstrb[0]) begin
        mode_q <= pwdata[MAC_MODE_W-1:0];  // [R12]
      end
    end
  end

  // soft trigger is held until the sequencer is idle so a pulse during a conversion is kept; a further pulse while one is held is merged into it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_req_q <= 1'b0;
      flush_q    <= 1'b0;
    end else begin
      flush_q <= wr_hit && is_off(paddr, MAC_OFF_FRESET);  // [R16]
      if (wr_hit && is_off(paddr, MAC_OFF_TRIG) && mode_q[MAC_MODE_SOFT]) begin
        soft_req_q <= 1'b1;  // [R15]
      end else if (start) begin
        soft_req_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= MAC_IDLE;
      conv_cnt_q <= '0;
      scan_ch_q  <= '0;
      hold_q     <= '0;
    end else begin
      unique case (state_q)
        MAC_IDLE: begin
          if (start) begin
            state_q    <= MAC_CONV;
            conv_cnt_q <= CW'(CONV_CYC);
          end
        end
        MAC_CONV: begin
          if (conv_cnt_q == CW'(1)) begin
            hold_q  <= {mux_channel, adc_sample};
            state_q <= MAC_STORE;
          end else begin
            conv_cnt_q <= conv_cnt_q - 1'b1;
          end
        end
        MAC_STORE: begin
          // a full fifo drops the sample; the full flag warns software
          state_q <= MAC_IDLE;
          if (!mode_q[MAC_MODE_SCAN] || scan_ch_q >= channel_select_q) begin
            scan_ch_q <= '0;  // [R6]
          end else begin
            scan_ch_q <= scan_ch_q + 1'b1;  // [R6]
          end
        end
        default: state_q <= MAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_channel <= '0;
      pga_gain    <= MAC_GAIN_X1;  // [R7]
    end else begin
      mux_channel <= mode_q[MAC_MODE_SCAN] ? scan_ch_q : channel_select_q;  // [R5] [R6]
      pga_gain    <= gain_code_q;
    end
  end

  // fifo off: the last result is kept in a plain flip-flop register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_q <= '0;
      lost_q  <= 1'b0;
    end else begin
      if (!fifo_on && state_q == MAC_STORE) begin
        entry_q <= hold_q;
      end
      if (flush_q) begin
        lost_q <= 1'b0;
      end else if (push_if.valid && !push_if.ready) begin
        lost_q <= 1'b1;  // [R10]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
      if (setup && !pwrite) begin
        if (is_off(paddr, MAC_OFF_DATA)) begin
          prdata_q <= {20'h00000, head[MAC_SAMPLE_W-1:0]};  // [R1] [R18]
        end else if (is_off(paddr, MAC_OFF_TAGGED)) begin
          prdata_q <= tag_word(head);  // [R2] [R3]
        end else if (is_off(paddr, MAC_OFF_CHAN)) begin
          prdata_q <= {27'h0000000, channel_select_q};
        end else if (is_off(paddr, MAC_OFF_GAIN)) begin
          prdata_q <= {30'h00000000, gain_code_q};  // [R8]
        end else if (is_off(paddr, MAC_OFF_MODE)) begin
          prdata_q <= {28'h0000000, mode_q};  // [R13]
        end else if (is_off(paddr, MAC_OFF_STATUS)) begin
          prdata_q[MAC_ST_EMPTY] <= (fcount == '0);  // [R9]
          prdata_q[MAC_ST_HALF]  <= (fcount >= FW'(FIFO_DEPTH / 2));  // [R9]
          prdata_q[MAC_ST_FULL]  <= (fcount == FW'(FIFO_DEPTH)) || lost_q;  // [R10]
          prdata_q[MAC_ST_BUSY]  <= (state_q != MAC_IDLE);  // [R11]
        end else if (!is_off(paddr, MAC_OFF_TRIG) && !is_off(paddr, MAC_OFF_FRESET)) begin
          pslverr_q <= 1'b1;
        end
      end else if (setup && pwrite) begin
        pslverr_q <= !(is_off(paddr, MAC_OFF_CHAN) || is_off(paddr, MAC_OFF_GAIN) ||
                       is_off(paddr, MAC_OFF_MODE) || is_off(paddr, MAC_OFF_TRIG) ||
                       is_off(paddr, MAC_OFF_FRESET));
      end
    end
  end
endmodule
